// *** hw/switch_out.v ***
// switch output decision block: two configurable switches with register port
//
// The plain strobed port and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
`include "switch_out_regs.vh"
module switch_out #(
    parameter DW = 16,
    parameter CW = 16,
    parameter TICK_CYCLES = `SW_DLY_UNIT_CYCLES
) (
    // clock and reset
    input wire clk,
    input wire reset,
    // measurement result
    input wire meas_done,
    input wire [DW-1:0] distance,
    input wire echo_ok,
    // register port
    input wire [7:0] addr,
    input wire [31:0] wdata,
    input wire wr,
    input wire rd,
    output reg [31:0] rdata,
    // switch drivers
    output reg [1:0] sink_on,
    output reg [1:0] source_on,
    // interrupt
    output wire irq
);
    reg [DW-1:0] range_min_reg;
    reg [DW-1:0] range_max_reg;
    reg [`SW_STAT_W-1:0] status_reg;
    reg [`SW_STAT_W-1:0] mask_reg;
    reg [31:0] tick_div_reg;
    reg [31:0] tick_cnt_reg;
    reg tick_reg;
    reg [7:0] ctrl_reg [0:1];
    reg [DW-1:0] sp_reg [0:1];
    reg [DW-1:0] hyst_reg [0:1];
    reg [DW-1:0] win_reg [0:1];
    reg [CW-1:0] on_reg [0:1];
    reg [CW-1:0] off_reg [0:1];
    reg [CW-1:0] nt_reg [0:1];
    reg [1:0] state_d_reg;
    reg lost_d_reg;
    wire [1:0] state;
    wire [1:0] lost;
    wire target_ok;
    wire sw_hit = (addr >= `SW_ADDR_SW_BASE) && (addr < `SW_ADDR_SW_BASE + 8'h40);
    // switch 0 sits at 0x20..0x3F (bit 5 set), switch 1 at 0x40..0x5F (bit 5 clear)
    wire sel = ~addr[5];
    wire [4:0] sub = addr[4:0];
    wire [`SW_STAT_W-1:0] events;
    integer i;

    // range gate on the incoming result
    assign target_ok = echo_ok && (distance >= range_min_reg)
        && (distance <= range_max_reg);

    // delay time base
    always @(posedge clk) begin
        if (reset) begin
            tick_cnt_reg <= 32'h00000000;
            tick_reg <= 1'b0;
        end else if (tick_cnt_reg + 32'h00000001 >= tick_div_reg) begin
            tick_cnt_reg <= 32'h00000000;
            tick_reg <= 1'b1;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 32'h00000001;
            tick_reg <= 1'b0;
        end
    end

    // register writes
    always @(posedge clk) begin
        if (reset) begin
            range_min_reg <= `SW_RST_RANGE_MIN;
            range_max_reg <= `SW_RST_RANGE_MAX;
            mask_reg <= {`SW_STAT_W{1'b0}};
            tick_div_reg <= TICK_CYCLES;
            ctrl_reg[0] <= `SW_RST_CTRL0;
            ctrl_reg[1] <= `SW_RST_CTRL1;
            sp_reg[0] <= `SW_RST_SP0;
            sp_reg[1] <= `SW_RST_SP1;
            for (i = 0; i < 2; i = i + 1) begin
                hyst_reg[i] <= `SW_RST_HYST;
                win_reg[i] <= `SW_RST_WIN;
                on_reg[i] <= {CW{1'b0}};
                off_reg[i] <= {CW{1'b0}};
                nt_reg[i] <= {CW{1'b0}};
            end
        end else if (wr) begin
            case (addr)
                `SW_ADDR_RANGE_MIN: range_min_reg <= wdata[DW-1:0];
                `SW_ADDR_RANGE_MAX: range_max_reg <= wdata[DW-1:0];
                `SW_ADDR_MASK: mask_reg <= wdata[`SW_STAT_W-1:0];
                `SW_ADDR_TICK_DIV: tick_div_reg <= wdata;
                default: begin
                    if (sw_hit) begin
                        case (sub)
                            `SW_SUB_CTRL: ctrl_reg[sel] <= wdata[7:0];
                            `SW_SUB_SETPOINT: sp_reg[sel] <= wdata[DW-1:0];
                            `SW_SUB_HYST: hyst_reg[sel] <= wdata[DW-1:0];
                            `SW_SUB_WINDOW: win_reg[sel] <= wdata[DW-1:0];
                            `SW_SUB_ON_DLY: on_reg[sel] <= wdata[CW-1:0];
                            `SW_SUB_OFF_DLY: off_reg[sel] <= wdata[CW-1:0];
                            `SW_SUB_NT_DLY: nt_reg[sel] <= wdata[CW-1:0];
                            default: ;
                        endcase
                    end
                end
            endcase
        end
    end

    // two independent channels
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : chan
            switch_eval #(.DW(DW), .CW(CW)) u_eval (
                .clk(clk),
                .reset(reset),
                .meas_done(meas_done),
                .tick(tick_reg),
                .distance(distance),
                .target_ok(target_ok),
                .ctrl(ctrl_reg[g]),
                .setpoint(sp_reg[g]),
                .hyst(hyst_reg[g]),
                .win_size(win_reg[g]),
                .on_delay(on_reg[g]),
                .off_delay(off_reg[g]),
                .nt_delay(nt_reg[g]),
                .state(state[g]),
                .lost(lost[g])
            );
        end
    endgenerate

    // output stage by switch type
    always @(posedge clk) begin
        if (reset) begin
            sink_on <= 2'h0;
            source_on <= 2'h0;
        end else begin
            for (i = 0; i < 2; i = i + 1) begin
                sink_on[i] <= state[i]
                    && ctrl_reg[i][`SW_CTRL_TYPE_HI:`SW_CTRL_TYPE_LO] == `SW_TYPE_SINK;
                source_on[i] <= state[i]
                    && ctrl_reg[i][`SW_CTRL_TYPE_HI:`SW_CTRL_TYPE_LO] == `SW_TYPE_SOURCE;
            end
        end
    end

    // sticky status, set wins over write-one clear
    assign events = {(lost[0] | lost[1]) & ~lost_d_reg, meas_done,
        state[1] ^ state_d_reg[1], state[0] ^ state_d_reg[0]};

    always @(posedge clk) begin
        if (reset) begin
            status_reg <= {`SW_STAT_W{1'b0}};
            state_d_reg <= 2'h0;
            lost_d_reg <= 1'b0;
        end else begin
            state_d_reg <= state;
            lost_d_reg <= lost[0] | lost[1];
            if (wr && addr == `SW_ADDR_STATUS) begin
                status_reg <= (status_reg & ~wdata[`SW_STAT_W-1:0]) | events;
            end else begin
                status_reg <= status_reg | events;
            end
        end
    end

    assign irq = |(status_reg & mask_reg);

    // read data one cycle after the strobe
    always @(posedge clk) begin
        if (reset) begin
            rdata <= 32'h00000000;
        end else if (rd) begin
            rdata <= 32'h00000000;
            case (addr)
                `SW_ADDR_RANGE_MIN: rdata[DW-1:0] <= range_min_reg;
                `SW_ADDR_RANGE_MAX: rdata[DW-1:0] <= range_max_reg;
                `SW_ADDR_STATUS: rdata[`SW_STAT_W-1:0] <= status_reg;
                `SW_ADDR_MASK: rdata[`SW_STAT_W-1:0] <= mask_reg;
                `SW_ADDR_STATE: rdata[3:0] <= {lost, state};
                `SW_ADDR_TICK_DIV: rdata <= tick_div_reg;
                default: begin
                    if (sw_hit) begin
                        case (sub)
                            `SW_SUB_CTRL: rdata[7:0] <= ctrl_reg[sel];
                            `SW_SUB_SETPOINT: rdata[DW-1:0] <= sp_reg[sel];
                            `SW_SUB_HYST: rdata[DW-1:0] <= hyst_reg[sel];
                            `SW_SUB_WINDOW: rdata[DW-1:0] <= win_reg[sel];
                            `SW_SUB_ON_DLY: rdata[CW-1:0] <= on_reg[sel];
                            `SW_SUB_OFF_DLY: rdata[CW-1:0] <= off_reg[sel];
                            `SW_SUB_NT_DLY: rdata[CW-1:0] <= nt_reg[sel];
                            default: ;
                        endcase
                    end
                end
            endcase
        end
    end
endmodule // switch_out

// *** common/switch_out_regs.vh ***
// register offsets, field positions, reset values and timing figures of the switch output block
`ifndef SWITCH_OUT_REGS_VH
`define SWITCH_OUT_REGS_VH

// register word addresses (8-bit address port)
`define SW_ADDR_RANGE_MIN   8'h00
`define SW_ADDR_RANGE_MAX   8'h04
`define SW_ADDR_STATUS      8'h08
`define SW_ADDR_MASK        8'h0C
`define SW_ADDR_STATE       8'h10
`define SW_ADDR_TICK_DIV    8'h14
`define SW_ADDR_SW_BASE     8'h20
`define SW_SW_STRIDE        8'h20
// per-switch sub-offsets
`define SW_SUB_CTRL         5'h00
`define SW_SUB_SETPOINT     5'h04
`define SW_SUB_HYST         5'h08
`define SW_SUB_WINDOW       5'h0C
`define SW_SUB_ON_DLY       5'h10
`define SW_SUB_OFF_DLY      5'h14
`define SW_SUB_NT_DLY       5'h18

// per-switch control fields
`define SW_CTRL_POL         0
`define SW_CTRL_MODE        1
`define SW_CTRL_WPOL        2
`define SW_CTRL_PWRUP       3
`define SW_CTRL_NT_LO       4
`define SW_CTRL_NT_HI       5
`define SW_CTRL_TYPE_LO     6
`define SW_CTRL_TYPE_HI     7

// no-target responses
`define SW_NT_HOLD          2'h0
`define SW_NT_ON            2'h1
`define SW_NT_OFF           2'h2
// output types
`define SW_TYPE_OFF         2'h0
`define SW_TYPE_SINK        2'h1
`define SW_TYPE_SOURCE      2'h2

// status bits: switch change events, measurement done, target lost
`define SW_STAT_CHG0        0
`define SW_STAT_CHG1        1
`define SW_STAT_MEAS        2
`define SW_STAT_LOST        3
`define SW_STAT_W           4

// reset values: switch 0 low alarm, switch 1 high alarm
`define SW_RST_CTRL0        8'h41
`define SW_RST_CTRL1        8'h40
`define SW_RST_SP0          16'h0400
`define SW_RST_SP1          16'h2000
`define SW_RST_HYST         16'h0040
`define SW_RST_WIN          16'h0400
`define SW_RST_RANGE_MIN    16'h0100
`define SW_RST_RANGE_MAX    16'hF000

// delay time base: one delay unit in ms
`define SW_DLY_UNIT_MS      1
`define SW_CLK_MHZ          100
`define SW_DLY_UNIT_CYCLES  (`SW_DLY_UNIT_MS * `SW_CLK_MHZ * 1000)

`endif

// *** hw/delay_qual.v ***
// timer that qualifies a condition held for a programmed number of ticks
`timescale 1ns/10ps
module delay_qual #(
    parameter CW = 16
) (
    // clock and reset
    input wire clk,
    input wire reset,
    // control
    input wire tick,
    input wire cond,
    input wire hold,
    input wire [CW-1:0] delay,
    // result
    output wire done
);
    reg [CW-1:0] count_reg;
    reg run_reg;

    // a zero delay qualifies as soon as the condition stands
    assign done = cond && (delay == {CW{1'b0}} || (run_reg && count_reg >= delay));

    always @(posedge clk) begin
        if (reset) begin
            count_reg <= {CW{1'b0}};
            run_reg <= 1'b0;
        end else if (!cond) begin
            count_reg <= {CW{1'b0}};
            run_reg <= 1'b0;
        end else if (!hold) begin
            run_reg <= 1'b1;
            if (tick && count_reg != {CW{1'b1}}) begin
                count_reg <= count_reg + {{(CW-1){1'b0}}, 1'b1};
            end
        end
    end
endmodule // delay_qual

// *** hw/switch_eval.v ***
// one switch channel: compare, qualify and drive the switch state
`timescale 1ns/10ps
`include "switch_out_regs.vh"
module switch_eval #(
    parameter DW = 16,
    parameter CW = 16
) (
    // clock and reset
    input wire clk,
    input wire reset,
    // measurement
    input wire meas_done,
    input wire tick,
    input wire [DW-1:0] distance,
    input wire target_ok,
    // configuration
    input wire [7:0] ctrl,
    input wire [DW-1:0] setpoint,
    input wire [DW-1:0] hyst,
    input wire [DW-1:0] win_size,
    input wire [CW-1:0] on_delay,
    input wire [CW-1:0] off_delay,
    input wire [CW-1:0] nt_delay,
    // state
    output wire state,
    output wire lost
);
    reg state_reg;
    reg first_reg;
    reg near_reg;
    reg in_win_reg;
    reg want_reg;
    reg [DW:0] far_edge;
    reg [DW:0] hyst_lo;
    reg [DW:0] hyst_hi;
    wire pol = ctrl[`SW_CTRL_POL];
    wire mode = ctrl[`SW_CTRL_MODE];
    wire wpol = ctrl[`SW_CTRL_WPOL];
    wire [1:0] nt_sel = ctrl[`SW_CTRL_NT_HI:`SW_CTRL_NT_LO];
    wire on_ok;
    wire off_ok;
    wire nt_ok;

    // desired state from the last measurement
    always @* begin
        far_edge = {1'b0, setpoint} + {1'b0, win_size};
        hyst_hi = {1'b0, setpoint} + {1'b0, hyst};
        hyst_lo = (setpoint > hyst) ? {1'b0, setpoint - hyst} : {(DW+1){1'b0}};
    end

    always @(posedge clk) begin
        if (reset) begin
            want_reg <= 1'b0;
            near_reg <= 1'b0;
            in_win_reg <= 1'b0;
        end else if (meas_done) begin
            if (mode) begin
                in_win_reg <= ({1'b0, distance} >= {1'b0, setpoint})
                    && ({1'b0, distance} <= far_edge);
                want_reg <= (({1'b0, distance} >= {1'b0, setpoint})
                    && ({1'b0, distance} <= far_edge)) ? wpol : ~wpol;
            end else if (pol) begin
                // on closer: off once farther than setpoint plus hysteresis
                if ({1'b0, distance} <= {1'b0, setpoint}) begin
                    want_reg <= 1'b1;
                end else if ({1'b0, distance} >= hyst_hi) begin
                    want_reg <= 1'b0;
                end else begin
                    want_reg <= state_reg;
                end
            end else begin
                // on farther: off once nearer than setpoint minus hysteresis
                if ({1'b0, distance} >= {1'b0, setpoint}) begin
                    want_reg <= 1'b1;
                end else if ({1'b0, distance} <= hyst_lo) begin
                    want_reg <= 1'b0;
                end else begin
                    want_reg <= state_reg;
                end
            end
            near_reg <= 1'b0;
        end
    end

    reg valid_reg;
    always @(posedge clk) begin
        if (reset) begin
            valid_reg <= 1'b0;
        end else if (meas_done) begin
            valid_reg <= target_ok;
        end
    end

    // no-target timing; on/off qualification clears and restarts while no target is valid
    delay_qual #(.CW(CW)) nt_q (
        .clk(clk), .reset(reset), .tick(tick), .cond(~valid_reg & ~first_reg),
        .hold(1'b0), .delay(nt_delay), .done(nt_ok)
    );
    delay_qual #(.CW(CW)) on_q (
        .clk(clk), .reset(reset), .tick(tick), .cond(valid_reg & want_reg),
        .hold(1'b0), .delay(on_delay), .done(on_ok)
    );
    delay_qual #(.CW(CW)) off_q (
        .clk(clk), .reset(reset), .tick(tick), .cond(valid_reg & ~want_reg),
        .hold(1'b0), .delay(off_delay), .done(off_ok)
    );

    always @(posedge clk) begin
        if (reset) begin
            first_reg <= 1'b1;
            state_reg <= ctrl[`SW_CTRL_PWRUP];
        end else if (first_reg) begin
            state_reg <= ctrl[`SW_CTRL_PWRUP];
            if (meas_done) begin
                first_reg <= 1'b0;
            end
        end else if (!valid_reg) begin
            if (nt_ok) begin
                case (nt_sel)
                    `SW_NT_ON: state_reg <= 1'b1;
                    `SW_NT_OFF: state_reg <= 1'b0;
                    default: state_reg <= state_reg;
                endcase
            end
        end else if (on_ok) begin
            state_reg <= 1'b1;
        end else if (off_ok) begin
            state_reg <= 1'b0;
        end
    end

    assign state = state_reg;
    assign lost = ~valid_reg & ~first_reg;
endmodule // switch_eval

// *** dv/user_equip.sv ***
// user equipment model reading the two switch wires through its loads
`timescale 1ns/10ps
module user_equip (
    // switch drivers
    input wire [1:0] sink_on,
    input wire [1:0] source_on,
    // levels seen at the equipment inputs
    output wire [1:0] sink_line,
    output wire [1:0] source_line
);
    // sinking wire has a pull-up, low only while the transistor conducts
    assign sink_line = ~sink_on;
    // sourcing wire has a pull-down, high only while driven
    assign source_line = source_on;
endmodule // user_equip

// *** dv/switch_out_chk.sv ***
// port checker for the switch output block and its bind
`timescale 1ns/10ps
`include "switch_out_regs.vh"
module switch_out_chk #(
    parameter DW = 16,
    parameter CW = 16,
    parameter TICK_CYCLES = 4
) (
    // clock and reset
    input wire clk,
    input wire reset,
    // measurement
    input wire meas_done,
    input wire [DW-1:0] distance,
    input wire echo_ok,
    // register port
    input wire [7:0] addr,
    input wire [31:0] wdata,
    input wire wr,
    input wire rd,
    input wire [31:0] rdata,
    // outputs
    input wire [1:0] sink_on,
    input wire [1:0] source_on,
    input wire irq
);
    reg seen_meas;
    reg [2:0] up_cnt;
    reg [3:0] mask_q;
    reg [1:0] snk_ok, src_ok;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    // mirror of mask and output types, both switches default to sink
    always @(posedge clk) begin
        if (reset) begin
            seen_meas <= 1'b0;
            up_cnt <= 3'h0;
            mask_q <= 4'h0;
            snk_ok <= 2'b11;
            src_ok <= 2'b00;
        end else begin
            seen_meas <= seen_meas | meas_done;
            up_cnt <= up_cnt + {2'b00, up_cnt != 3'h7};
            if (wr && addr == `SW_ADDR_MASK)
                mask_q <= wdata[3:0];
            if (wr && addr == `SW_ADDR_SW_BASE) begin
                snk_ok[0] <= wdata[7:6] == `SW_TYPE_SINK;
                src_ok[0] <= wdata[7:6] == `SW_TYPE_SOURCE;
            end
            if (wr && addr == `SW_ADDR_SW_BASE + `SW_SW_STRIDE) begin
                snk_ok[1] <= wdata[7:6] == `SW_TYPE_SINK;
                src_ok[1] <= wdata[7:6] == `SW_TYPE_SOURCE;
            end
        end
    end
    a_rdata_hold: assert property (!$past(rd) |-> $stable(rdata))
        else $error("read data moved with no read");
    a_state_upper: assert property (rd && addr == `SW_ADDR_STATE |=> rdata[31:4] == 28'h0)
        else $error("state read has upper bits set");
    a_sink_excl: assert property ((sink_on & source_on) == 2'b00)
        else $error("switch sinks and sources at once");
    a_sink_type: assert property ((sink_on & ~(snk_ok | $past(snk_ok))) == 2'b00)
        else $error("sink driven on a switch of other type");
    a_source_type: assert property ((source_on & ~(src_ok | $past(src_ok))) == 2'b00)
        else $error("source driven on a switch of other type");
    a_pwrup_hold: assert property (
        !seen_meas && up_cnt == 3'h7 && !$past(wr) && !$past(wr, 2) && !$past(wr, 3)
        |-> $stable(sink_on) && $stable(source_on)) else $error("outputs moved before a result");
    a_irq_masked: assert property (mask_q == 4'h0 |-> !irq)
        else $error("interrupt with all sources masked");
    a_irq_meas: assert property (meas_done && mask_q[`SW_STAT_MEAS] |-> ##[1:4] irq)
        else $error("no interrupt after an unmasked result");
    c_meas_ok: cover property (meas_done && echo_ok);
    c_meas_lost: cover property (meas_done && !echo_ok);
    c_irq_up: cover property ($rose(irq));
endmodule // switch_out_chk

bind switch_out switch_out_chk #(.DW(DW), .CW(CW), .TICK_CYCLES(TICK_CYCLES)) chk (
    .clk(clk), .reset(reset), .meas_done(meas_done), .distance(distance), .echo_ok(echo_ok),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .sink_on(sink_on),
    .source_on(source_on), .irq(irq));

// *** dv/switch_out_test.sv ***
// self-checking bench for the switch output block
`timescale 1ns/10ps
`include "switch_out_regs.vh"
module switch_out_test;
    localparam [7:0] S0 = `SW_ADDR_SW_BASE;
    localparam [7:0] S1 = S0 + `SW_SW_STRIDE;
    localparam [7:0] C0 = `SW_RST_CTRL0;
    localparam [7:0] C1 = `SW_RST_CTRL1;
    reg clk, reset, meas_done, echo_ok, wr, rd;
    reg [15:0] distance;
    reg [7:0] addr;
    reg [31:0] wdata, rd_val;
    wire [31:0] rdata;
    wire [1:0] sink_on, source_on, sink_line, source_line;
    wire irq;
    integer bad_count, num_checks, k;

    switch_out #(.TICK_CYCLES(4)) DUT (.clk(clk), .reset(reset), .meas_done(meas_done),
        .distance(distance), .echo_ok(echo_ok), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .sink_on(sink_on), .source_on(source_on), .irq(irq));
    user_equip ue (.sink_on(sink_on), .source_on(source_on), .sink_line(sink_line),
        .source_line(source_line));

    task test_done;
        begin
            $display("checks %0d mismatches %0d", num_checks, bad_count);
            if (bad_count == 0 && num_checks > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    task chk(input [31:0] seen, input [31:0] exp);
        begin
            num_checks = num_checks + 1;
            if (seen !== exp) begin
                bad_count = bad_count + 1;
                $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask
    // strobes drop for one edge so back-to-back calls never drive twice at once
    task wr_reg(input [7:0] a, input [31:0] d);
        begin
            addr <= a;
            wdata <= d;
            wr <= 1'b1;
            @(posedge clk);
            wr <= 1'b0;
            @(posedge clk);
        end
    endtask
    task rd_reg(input [7:0] a);
        begin
            addr <= a;
            rd <= 1'b1;
            @(posedge clk);
            rd <= 1'b0;
            #1 rd_val = rdata;
            @(posedge clk);
        end
    endtask
    // one result, then the state word once outputs have settled
    task m(input [15:0] d, input ok, input [1:0] e);
        begin
            distance <= d;
            echo_ok <= ok;
            meas_done <= 1'b1;
            @(posedge clk);
            meas_done <= 1'b0;
            repeat (4) @(posedge clk);
            rd_reg(`SW_ADDR_STATE);
            chk(rd_val[1:0], e);
        end
    endtask
    task wait_st(input [1:0] e);
        begin
            rd_reg(`SW_ADDR_STATE);
            for (k = 0; k < 50 && rd_val[1:0] !== e; k = k + 1)
                rd_reg(`SW_ADDR_STATE);
            chk(rd_val[1:0], e);
            if (rd_val[1:0] !== e)
                test_done;
        end
    endtask
    task t_defaults;
        begin
            rd_reg(S0);
            chk(rd_val, C0);
            rd_reg(S1);
            chk(rd_val, C1);
            rd_reg(`SW_ADDR_STATE);
            chk(rd_val, {C1[`SW_CTRL_PWRUP], C0[`SW_CTRL_PWRUP]});
            chk({30'h0, sink_line}, {30'h0, ~C1[`SW_CTRL_PWRUP], ~C0[`SW_CTRL_PWRUP]});
            rd_reg(8'h60);
            chk(rd_val, 32'h0);
        end
    endtask
    task t_setpoint;
        begin
            wr_reg(`SW_ADDR_TICK_DIV, 32'h4);
            for (k = 0; k < 6; k = k + 1)
                wr_reg(8'((k < 3 ? S0 : S1) + `SW_SUB_ON_DLY + (k % 3) * 4), 32'h0);
            wr_reg(S0 + `SW_SUB_SETPOINT, 32'h1000);
            wr_reg(S0 + `SW_SUB_HYST, 32'h100);
            m(16'h2800, 1'b1, 2'b10);
            m(16'h0F00, 1'b1, 2'b01);
            m(16'h1080, 1'b1, 2'b01);
            m(16'h1100, 1'b1, 2'b00);
            wr_reg(S0, 32'h40);
            m(16'h1100, 1'b1, 2'b01);
            m(16'h0F80, 1'b1, 2'b01);
            m(16'h0F00, 1'b1, 2'b00);
            chk({30'h0, sink_line}, 32'h3);
        end
    endtask
    task t_window;
        begin
            wr_reg(S0, 32'h46);
            wr_reg(S0 + `SW_SUB_WINDOW, 32'h400);
            wr_reg(S1, 32'h80);
            m(16'h1200, 1'b1, 2'b01);
            m(16'h1500, 1'b1, 2'b00);
            m(16'h0F00, 1'b1, 2'b00);
            m(16'h1400, 1'b1, 2'b01);
            wr_reg(S0, 32'h42);
            m(16'h1200, 1'b1, 2'b00);
            m(16'h2800, 1'b1, 2'b11);
            chk({28'h0, sink_line, source_line}, 32'hA);
        end
    endtask
    task t_target;
        begin
            wr_reg(S0, 32'h61);
            m(16'h0F00, 1'b1, 2'b01);
            m(16'h0F00, 1'b0, 2'b00);
            m(16'h0F00, 1'b1, 2'b01);
            m(16'hF800, 1'b1, 2'b00);
            m(16'h0F00, 1'b1, 2'b01);
            m(16'h0080, 1'b1, 2'b00);
            wr_reg(S0, 32'h51);
            m(16'h2800, 1'b1, 2'b10);
            m(16'h2800, 1'b0, 2'b11);
            wr_reg(S0, 32'h41);
            m(16'h2800, 1'b1, 2'b10);
            m(16'h2800, 1'b0, 2'b10);
            wr_reg(S0, 32'h61);
            wr_reg(S0 + `SW_SUB_NT_DLY, 32'h5);
            m(16'h0F00, 1'b1, 2'b01);
            m(16'h0F00, 1'b0, 2'b01);
            wait_st(2'b00);
        end
    endtask
    task t_delays;
        begin
            wr_reg(S0, 32'h41);
            wr_reg(S0 + `SW_SUB_NT_DLY, 32'h0);
            wr_reg(S0 + `SW_SUB_ON_DLY, 32'h4);
            m(16'h0F00, 1'b1, 2'b00);
            m(16'h2800, 1'b1, 2'b10);
            m(16'h0F00, 1'b1, 2'b00);
            wait_st(2'b01);
        end
    endtask
    task t_irq;
        begin
            wr_reg(`SW_ADDR_STATUS, 32'hF);
            wr_reg(`SW_ADDR_MASK, 32'h4);
            m(16'h0F00, 1'b1, 2'b01);
            chk(irq, 1'b1);
            wr_reg(`SW_ADDR_STATUS, 32'h4);
            chk(irq, 1'b0);
            wr_reg(`SW_ADDR_MASK, 32'h0);
            m(16'h0F00, 1'b1, 2'b01);
            chk(irq, 1'b0);
            rd_reg(`SW_ADDR_STATUS);
            chk(rd_val[`SW_STAT_MEAS], 1'b1);
        end
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        reset = 1'b1;
        {meas_done, echo_ok, wr, rd} = 4'h0;
        distance = 16'h0;
        addr = 8'h0;
        wdata = 32'h0;
        bad_count = 0;
        num_checks = 0;
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        repeat (8) @(posedge clk);
        t_defaults;
        t_setpoint;
        t_window;
        t_target;
        t_delays;
        t_irq;
        test_done;
    end
endmodule // switch_out_test
